// ### uec_pkg.sv
// uec_pkg: register map, field positions and carrier types for the endpoint control block
// assumes a 32-bit AHB-Lite register bus and sixteen endpoints
package uec_pkg;
    localparam int UEC_NUM_EP = 16;
    localparam logic [31:0] UEC_EP_BASE = 32'h0000_0000;
    localparam logic [31:0] UEC_EP_STRIDE = 32'h0000_0004;
    localparam logic [31:0] UEC_EP_SPAN = 32'h0000_0040;
    // event/status registers chosen for this block
    localparam logic [31:0] UEC_STALL_SET = 32'h0000_0040;
    localparam logic [31:0] UEC_DECIDE = 32'h0000_0044;
    localparam int UEC_B_HSHK = 0;
    localparam int UEC_B_STALL = 1;
    localparam int UEC_B_TXEN = 2;
    localparam int UEC_B_RXEN = 3;
    localparam int UEC_B_CONDIS = 4;
    localparam int UEC_B_NAK_RETRY_DISABLE = 6;
    localparam int UEC_B_LOW_SPEED_DIRECT_ENABLE = 7;
    localparam logic [7:0] UEC_EP_RESET = 8'h00;
    localparam logic [7:0] UEC_MASK_EP0 = 8'hDF;
    localparam logic [7:0] UEC_MASK_EPN = 8'h1F;
    localparam logic [1:0] UEC_HTRANS_NONSEQ = 2'h2;
    typedef struct packed {
        logic low_speed_direct_enable;
        logic nak_retry_disable;
        logic setup_transfer_disable;
        logic endpoint_receive_enable;
        logic endpoint_transmit_enable;
        logic endpoint_stalled_flag;
        logic endpoint_handshake_enable;
    } uec_ctrl_s;
    typedef struct packed {
        logic [3:0] ep;
        logic is_setup;
        logic is_rx;
        logic is_tx;
    } uec_tok_s;
endpackage

// ### uec_regfile.sv
// uec_regfile: sixteen 8-bit endpoint control words with registered read data
// assumes one write port and one read port on the same clock
`timescale 1ns/1ps
module uec_regfile
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [3:0] raddr,
    output logic [7:0] rdata_q,
    output logic [127:0] all_q
);
    import uec_pkg::*;
    logic [7:0] mem_q [UEC_NUM_EP];
    genvar g;
    generate
        for (g = 0; g < UEC_NUM_EP; g++)
        begin : g_ep
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    mem_q[g] <= UEC_EP_RESET;
                else if (we && waddr == 4'(g))
                    mem_q[g] <= wdata;
            end
            assign all_q[g*8 +: 8] = mem_q[g];
        end
    endgenerate
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= 8'h00;
        else
            rdata_q <= mem_q[raddr];
    end
endmodule // uec_regfile

// ### uec_top.sv
// uec_top: endpoint control registers on AHB-Lite, plus a token admission check
// assumes a single AHB-Lite master; the packet engine presents tokens and stall events
//
// Contract
// R1: sixteen independent endpoint control registers; bits 15..8 read zero.
// R2: bit 5 ignores writes and reads zero.
// R3: endpoint 0 bit 6 set disables hardware NAK retry; clear enables it.
// R4: with tx and rx enabled, bit 4 set rejects setup transfers.
// R5: bit 4 is ignored unless both tx and rx are enabled.
// R6: receive traffic accepted only while bit 3 is set.
// R7: no transmit while bit 2 is clear.
// R8: bit 1 reads one once the endpoint has been stalled.
// R9: endpoint 0 bit 7 enables low-speed direct connection in host mode.
`timescale 1ns/1ps
module uec_top
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire uec_pkg::uec_tok_s tok,
    input wire logic tok_valid,
    input wire logic stall_evt,
    input wire logic [3:0] stall_ep,
    input wire logic host_mode,
    output logic tok_accept_q,
    output logic tok_reject_q,
    output logic hw_nak_retry_q,
    output logic low_speed_direct_q,
    output uec_pkg::uec_ctrl_s ep0_ctrl_q
);
    import uec_pkg::*;

    function automatic logic is_ep(input logic [31:0] a);
        is_ep = a < UEC_EP_SPAN;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // address phase capture
    logic ap_wr_q, ap_rd_q;
    logic [31:0] ap_addr_q;
    logic ap_valid_q;
    wire take = hsel && hready && htrans == UEC_HTRANS_NONSEQ;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr_q <= 1'b0;
            ap_rd_q <= 1'b0;
            ap_addr_q <= 32'h0000_0000;
            ap_valid_q <= 1'b0;
        end
        else
        begin
            ap_wr_q <= take && hwrite;
            ap_rd_q <= take && !hwrite;
            ap_valid_q <= take;
            if (take)
                ap_addr_q <= haddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register storage and write masking
    wire [3:0] w_ep = ap_addr_q[5:2];
    wire ep_wr = ap_wr_q && is_ep(ap_addr_q);
    // bit 5 always dropped; bits 7..6 only exist on endpoint 0
    wire [7:0] w_mask = (w_ep == 4'h0) ? UEC_MASK_EP0 : UEC_MASK_EPN; // see R2 see R3 see R9
    logic [127:0] all_q;
    logic [7:0] rf_rdata;
    logic [7:0] wr_val;
    logic [15:0] stalled_q;
    // a hardware stall event outranks a software clear in the same cycle
    wire [15:0] stall_hit = stall_evt ? (16'h0001 << stall_ep) : 16'h0000;
    assign wr_val = (hwdata[7:0] & w_mask) & ~(8'h01 << UEC_B_STALL);
    uec_regfile u_rf
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(ep_wr),
        .waddr(w_ep),
        .wdata(wr_val),
        .raddr(haddr[5:2]),
        .rdata_q(rf_rdata),
        .all_q(all_q)
    );
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stalled_q <= 16'h0000;
        else
            stalled_q <= (stalled_q & ~((ep_wr && hwdata[UEC_B_STALL]) ?
                (16'h0001 << w_ep) : 16'h0000)) | stall_hit; // see R8
    end

    ////////////////////////////////////////////////////////////////////////
    // read data; upper bits zero
    logic [31:0] rd_addr_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_addr_q <= 32'h0000_0000;
        else if (take)
            rd_addr_q <= haddr;
    end
    wire [7:0] rd_byte = rf_rdata | ({7'h00, stalled_q[rd_addr_q[5:2]]} << UEC_B_STALL);
    wire [31:0] rd_word = is_ep(rd_addr_q) ? {24'h000000, rd_byte} : // see R1
                          (rd_addr_q == UEC_STALL_SET) ? {16'h0000, stalled_q} :
                          (rd_addr_q == UEC_DECIDE) ?
                          {30'h0, tok_reject_q, tok_accept_q} : 32'h0000_0000;
    assign hrdata = ap_rd_q ? rd_word : 32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // token admission
    wire [7:0] tc = all_q[tok.ep*8 +: 8];
    wire both_en = tc[UEC_B_TXEN] && tc[UEC_B_RXEN];
    wire setup_ok = !(both_en && tc[UEC_B_CONDIS]); // see R4 see R5
    wire rx_ok = tc[UEC_B_RXEN]; // see R6
    wire tx_ok = tc[UEC_B_TXEN]; // see R7
    wire ok = tok.is_setup ? setup_ok : tok.is_rx ? rx_ok : tok.is_tx ? tx_ok : 1'b0;
    wire [7:0] e0 = all_q[7:0];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tok_accept_q <= 1'b0;
            tok_reject_q <= 1'b0;
            hw_nak_retry_q <= 1'b1;
            low_speed_direct_q <= 1'b0;
            ep0_ctrl_q <= '0;
        end
        else
        begin
            tok_accept_q <= tok_valid && ok;
            tok_reject_q <= tok_valid && !ok;
            hw_nak_retry_q <= !e0[UEC_B_NAK_RETRY_DISABLE]; // see R3
            low_speed_direct_q <= host_mode && e0[UEC_B_LOW_SPEED_DIRECT_ENABLE]; // see R9
            ep0_ctrl_q <= {e0[7:6], e0[4:2], stalled_q[0], e0[0]};
        end
    end

    a_rx_gate: assert property (@(posedge hclk) disable iff (!hresetn) // see R6
        tok_valid && tok.is_rx && !tok.is_setup && !rx_ok |=> !tok_accept_q)
        else $error("rx accepted while disabled");
    a_tx_gate: assert property (@(posedge hclk) disable iff (!hresetn) // see R7
        tok_valid && tok.is_tx && !tok.is_rx && !tok.is_setup && !tx_ok |=> tok_reject_q)
        else $error("tx accepted while disabled");
    a_setup_rej: assert property (@(posedge hclk) disable iff (!hresetn) // see R4
        tok_valid && tok.is_setup && both_en && tc[UEC_B_CONDIS] |=> tok_reject_q)
        else $error("setup not rejected");
    a_setup_ign: assert property (@(posedge hclk) disable iff (!hresetn) // see R5
        tok_valid && tok.is_setup && !both_en |=> tok_accept_q)
        else $error("condis not ignored");
    a_stall_set: assert property (@(posedge hclk) disable iff (!hresetn) // see R8
        stall_evt |=> stalled_q[$past(stall_ep)])
        else $error("stall lost");
    a_bit5_zero: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
        ap_rd_q && is_ep(rd_addr_q) |-> hrdata[5] == 1'b0)
        else $error("bit 5 nonzero");
    a_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
        ap_rd_q && is_ep(rd_addr_q) |-> hrdata[31:8] == 24'h0)
        else $error("upper bits nonzero");
    a_retry: assert property (@(posedge hclk) disable iff (!hresetn) // see R3
        ##1 hw_nak_retry_q == !$past(e0[UEC_B_NAK_RETRY_DISABLE]))
        else $error("retry mismatch");
    a_low_speed_direct_enable: assert property (@(posedge hclk) disable iff (!hresetn) // see R9
        !host_mode |=> !low_speed_direct_q)
        else $error("low_speed_direct_enable outside host mode");
endmodule // uec_top

// ### uec_usb_peer.sv
// uec_usb_peer: far-side token source, one token per request cycle
// assumes requests change just after a rising edge of hclk
`timescale 1ns/1ps
module uec_usb_peer
(
    input wire logic hclk,
    input wire logic go,
    input wire logic [3:0] ep,
    input wire logic [1:0] kind,
    output uec_pkg::uec_tok_s tok,
    output logic tok_valid
);
    import uec_pkg::*;
    logic [6:0] last_q = 7'h00;
    // idle lines carry the inverse of the last token, never a stale copy
    assign tok = go ? {ep, kind == 2'h0, kind == 2'h1, kind == 2'h2} : ~last_q;
    assign tok_valid = go;
    always_ff @(posedge hclk)
        if (go) last_q <= tok;
endmodule // uec_usb_peer

// ### tb.sv
// tb: self-checking bench for uec_top against a register and token model
// assumes a zero-wait AHB-Lite slave and the peer token source
`timescale 1ns/1ps
`define CHK(g,e) begin n_tests++; if ((g)!==(e)) begin bad_count++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb;
    import uec_pkg::*;
    logic hclk = 0, hresetn = 0, hwrite = 0, hsel = 1, go = 0, stall_evt = 0, host_mode = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
    logic [1:0] htrans = 0, kind = 0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] ep = 0, stall_ep = 0;
    logic hreadyout, hresp, tok_valid, tok_accept_q, tok_reject_q;
    logic hw_nak_retry_q, low_speed_direct_q;
    uec_tok_s tok;
    uec_ctrl_s e0c;
    int bad_count = 0, n_tests = 0, seed = 65616, cyc = 0, m[16];
    always #20 hclk = ~hclk;
    uec_usb_peer peer (.hclk, .go, .ep, .kind, .tok, .tok_valid);
    uec_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tok, .tok_valid, .stall_evt,
        .stall_ep, .host_mode, .tok_accept_q, .tok_reject_q, .hw_nak_retry_q,
        .low_speed_direct_q, .ep0_ctrl_q(e0c));
    ////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= UEC_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        v = hrdata;
        @(posedge hclk);
    endtask
    task automatic wr(input int i, input logic [31:0] d);
        bus(1'b1, UEC_EP_BASE + 32'(4 * i), d);
        m[i] = 32'(d & (i == 0 ? UEC_MASK_EP0 : UEC_MASK_EPN) & 8'hFD);
    endtask
    task automatic ck(input int i);
        bus(1'b0, UEC_EP_BASE + 32'(4 * i), 32'h0);
        `CHK(v, 32'(m[i]))
        `CHK(hresp, 1'b0)
    endtask
    task automatic tk(input int e, input int k);
        logic [7:0] r;
        logic ex;
        r = m[e][7:0];
        ex = k == 0 ? !(r[2] & r[3] & r[4]) : k == 1 ? r[3] : k == 2 ? r[2] : 1'b0;
        ep <= 4'(e);
        kind <= 2'(k);
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
        `CHK({tok_accept_q, tok_reject_q}, {ex, !ex})
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK(hw_nak_retry_q, 1'b1)
        for (int i = 0; i < 16; i++) ck(i);
        repeat (40)
        begin
            host_mode <= 1'($random(seed));
            for (int i = 0; i < 16; i++) wr(i, $random(seed));
            // unmapped place: reads zero, write lost
            bus(1'b1, 32'h0000_0080, 32'hFFFF_FFFF);
            bus(1'b0, 32'h0000_0080, 32'h0);
            `CHK(v, 32'h0)
            for (int i = 0; i < 16; i++) ck(i);
            `CHK(hw_nak_retry_q, !m[0][6])
            `CHK(low_speed_direct_q, host_mode & m[0][7])
            `CHK(e0c, {m[0][7:6], m[0][4:2], 1'b0, m[0][0]})
            for (int i = 0; i < 16; i++) tk(i, $random(seed) & 3);
        end
        for (int k = 0; k < 16; k++)
        begin
            stall_ep <= 4'(k);
            stall_evt <= 1'b1;
            @(posedge hclk);
            stall_evt <= 1'b0;
            @(posedge hclk);
            m[k] = m[k] | 2;
            ck(k);
            bus(1'b0, UEC_STALL_SET, 32'h0);
            `CHK(v, 32'h0000_0001 << k)
            wr(k, 32'h0000_0002);
            ck(k);
        end
        report_and_stop();
    end
endmodule // tb
